// >>> rtl/sram_io_consts.vh
`ifndef SRAM_IO_CONSTS_VH
`define SRAM_IO_CONSTS_VH

// access kinds held in each pipeline stage
`define OP_W          2
`define OP_IDLE       2'h0
`define OP_READ       2'h1
`define OP_WRITE      2'h2

// burst order strap levels, burst counter width, start and step
`define BURST_LINEAR  1'h0
`define BURST_ILEAVE  1'h1
`define BURST_W       2
`define BURST_START   2'h0
`define BURST_STEP    2'h1

// buffer fill levels
`define BUF_EMPTY     2'h0
`define BUF_ONE       2'h1
`define BUF_FULL      2'h2

// reset values
`define BIT_LOW       1'h0
`define BIT_HIGH      1'h1
`define SYNC_LOW      3'h0
`define SYNC_HIGH     3'h7
`define RST_SYNC_LOW  2'h0
`define RST_SYNC_HIGH 2'h3

`endif

// >>> rtl/two_entry_buf.v
`timescale 1ns/1ps
module two_entry_buf
#(
    parameter W = 8
)
(
    // clock and reset
    input  wire         clk_i,
    input  wire         rst_n_i,
    input  wire         ce_i,
    // filling side
    input  wire         in_valid_i,
    output wire         in_ready_o,
    input  wire [W-1:0] in_data_i,
    // draining side
    output wire         out_valid_o,
    input  wire         out_ready_i,
    output wire [W-1:0] out_data_o
);

`include "sram_io_consts.vh"

reg [W-1:0] head_ff;
reg [W-1:0] tail_ff;
reg [1:0]   fill_ff;
wire        push;
wire        pop;

assign in_ready_o  = (fill_ff != `BUF_FULL);
assign out_valid_o = (fill_ff != `BUF_EMPTY);
assign out_data_o  = head_ff;
assign push        = ce_i & in_valid_i & in_ready_o;
assign pop         = ce_i & out_valid_o & out_ready_i;

always @(posedge clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        head_ff <= {W{`BIT_LOW}};
        tail_ff <= {W{`BIT_LOW}};
        fill_ff <= `BUF_EMPTY;
    end
    else if (push && !pop)
    begin
        if (fill_ff == `BUF_EMPTY)
            head_ff <= in_data_i;
        else
            tail_ff <= in_data_i;
        fill_ff <= fill_ff + `BUF_ONE;
    end
    else if (pop && !push)
    begin
        head_ff <= tail_ff;
        fill_ff <= fill_ff - `BUF_ONE;
    end
    else if (pop && push)
    begin
        if (fill_ff == `BUF_ONE)
            head_ff <= in_data_i;
        else
        begin
            head_ff <= tail_ff;
            tail_ff <= in_data_i;
        end
    end
end

endmodule // two_entry_buf

// >>> rtl/test_serial_io.v
`timescale 1ns/1ps
module test_serial_io
(
    // clock and reset
    input  wire clk_i,
    input  wire rst_n_i,
    input  wire ce_i,
    // test pins
    input  wire tck_i,
    input  wire tdi_i,
    output wire tdo_o
);

`include "sram_io_consts.vh"

reg  [2:0] tck_sync_ff;
reg  [2:0] tdi_sync_ff;
reg        tck_flt_ff;
reg        shift_ff;
reg        tdo_ff;
wire       tck_rise;
wire       tck_fall;

// change accepted once second and third stages agree
assign tck_rise = tck_sync_ff[1] & tck_sync_ff[2] & ~tck_flt_ff;
assign tck_fall = ~tck_sync_ff[1] & ~tck_sync_ff[2] & tck_flt_ff;
assign tdo_o    = tdo_ff;

always @(posedge clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        tck_sync_ff <= `SYNC_LOW;
        tdi_sync_ff <= `SYNC_LOW;
        tck_flt_ff  <= `BIT_LOW;
        shift_ff    <= `BIT_LOW;
        tdo_ff      <= `BIT_LOW;
    end
    else if (ce_i)
    begin
        tck_sync_ff <= {tck_sync_ff[1:0], tck_i};
        tdi_sync_ff <= {tdi_sync_ff[1:0], tdi_i};
        if (tck_sync_ff[1] == tck_sync_ff[2])
            tck_flt_ff <= tck_sync_ff[2];
        if (tck_rise)
            shift_ff <= tdi_sync_ff[2];
        if (tck_fall)
            tdo_ff <= shift_ff;
    end
end

endmodule // test_serial_io

// >>> rtl/sram_data_io.v
`timescale 1ns/1ps
module sram_data_io
#(
    parameter ADDR_W = 21,
    parameter LANES  = 4,
    parameter LANE_W = 8
)
(
    // clock and reset
    input  wire                      clk_i,
    input  wire                      arst_n_i,
    input  wire                      clk_en_i,
    // synchronous controls
    input  wire                      clock_gate_n_i,
    input  wire                      chip_sel_one_n_i,
    input  wire                      chip_sel_two_i,
    input  wire                      chip_sel_three_n_i,
    input  wire                      write_en_n_i,
    input  wire                      advance_or_load_i,
    input  wire [ADDR_W-1:0]         addr_i,
    input  wire [LANES-1:0]          byte_write_sel_n_i,
    // asynchronous output enable and strap
    input  wire                      out_en_n_i,
    input  wire                      burst_order_i,
    // data pins
    input  wire [LANES*LANE_W-1:0]   dq_i,
    output wire [LANES*LANE_W-1:0]   dq_o,
    output wire                      dq_oe_o,
    // parity pins
    input  wire [LANES-1:0]          parity_lines_i,
    output wire [LANES-1:0]          parity_lines_o,
    output wire                      parity_lines_oe_o,
    // test port pins
    input  wire                      tck_i,
    input  wire                      tdi_i,
    output wire                      tdo_o,
    // core read port
    output wire [ADDR_W-1:0]         rd_addr_o,
    output wire                      rd_en_o,
    input  wire [LANES*LANE_W-1:0]   rd_data_i,
    input  wire [LANES-1:0]          rd_parity_i,
    // core write stream
    output wire                      wr_valid_o,
    input  wire                      wr_ready_i,
    output wire [ADDR_W-1:0]         wr_addr_o,
    output wire [LANES-1:0]          wr_byte_en_o,
    output wire [LANES-1:0]          wr_parity_o,
    output wire [LANES*LANE_W-1:0]   wr_data_o
);

`include "sram_io_consts.vh"

localparam DATA_W = LANES * LANE_W;
localparam WORD_W = ADDR_W + LANES + LANES + DATA_W;

// ****************************************
// reset release
// ****************************************

reg  [1:0]          rst_sync_ff;
wire                rst_n;

always @(posedge clk_i or negedge arst_n_i)
begin
    if (!arst_n_i)
        rst_sync_ff <= `RST_SYNC_LOW;
    else
        rst_sync_ff <= {rst_sync_ff[0], `BIT_HIGH};
end

assign rst_n = rst_sync_ff[1];

// ****************************************
// burst order strap
// ****************************************

reg  [2:0]          mode_sync_ff;
reg                 mode_ff;
reg                 mode_taken_ff;
reg  [2:0]          mode_fill_ff;

// mode_ff rests interleaved until the strap has been sampled; the sync reset level is never used
always @(posedge clk_i or negedge rst_n)
begin
    if (!rst_n)
    begin
        mode_sync_ff  <= `SYNC_HIGH;
        mode_ff       <= `BURST_ILEAVE;
        mode_taken_ff <= `BIT_LOW;
        mode_fill_ff  <= `SYNC_LOW;
    end
    else if (clk_en_i)
    begin
        mode_sync_ff <= {mode_sync_ff[1:0], burst_order_i};
        mode_fill_ff <= {mode_fill_ff[1:0], `BIT_HIGH};
        // strap taken once all sync stages hold real samples and the last two agree, then held
        if (!mode_taken_ff && mode_fill_ff[2] && (mode_sync_ff[1] == mode_sync_ff[2]))
        begin
            mode_ff       <= mode_sync_ff[2];
            mode_taken_ff <= `BIT_HIGH;
        end
    end
end

// ****************************************
// clock qualification
// ****************************************

wire                buf_in_ready;
wire                step;
wire                selected;

// gate high only stretches the cycle, nothing is deselected
assign step     = clk_en_i & ~clock_gate_n_i & buf_in_ready;
assign selected = ~chip_sel_one_n_i & chip_sel_two_i & ~chip_sel_three_n_i;

// ****************************************
// address and control stage
// ****************************************

reg  [`OP_W-1:0]    s1_op_ff;
reg  [ADDR_W-1:0]   s1_base_ff;
reg  [`BURST_W-1:0] s1_cnt_ff;
reg  [LANES-1:0]    s1_bw_n_ff;
reg  [`BURST_W-1:0] burst_low;
wire [ADDR_W-1:0]   beat_addr;

always @(posedge clk_i or negedge rst_n)
begin
    if (!rst_n)
    begin
        s1_op_ff   <= `OP_IDLE;
        s1_base_ff <= {ADDR_W{`BIT_LOW}};
        s1_cnt_ff  <= `BURST_START;
        s1_bw_n_ff <= {LANES{`BIT_HIGH}};
    end
    else if (step)
    begin
        if (!advance_or_load_i)
        begin
            if (selected)
            begin
                s1_op_ff   <= write_en_n_i ? `OP_READ : `OP_WRITE;
                s1_base_ff <= addr_i;
                s1_cnt_ff  <= `BURST_START;
                s1_bw_n_ff <= byte_write_sel_n_i;
            end
            else
                s1_op_ff <= `OP_IDLE;
        end
        else if (s1_op_ff != `OP_IDLE)
        begin
            s1_cnt_ff  <= s1_cnt_ff + `BURST_STEP;
            s1_bw_n_ff <= byte_write_sel_n_i;
        end
    end
end

// low address bits walk per strap
always @*
begin
    if (mode_ff == `BURST_ILEAVE)
        burst_low = s1_base_ff[`BURST_W-1:0] ^ s1_cnt_ff;
    else
        burst_low = s1_base_ff[`BURST_W-1:0] + s1_cnt_ff;
end

assign beat_addr = {s1_base_ff[ADDR_W-1:`BURST_W], burst_low};
assign rd_addr_o = beat_addr;
assign rd_en_o   = step & (s1_op_ff == `OP_READ);

// ****************************************
// data phase stage and output register
// ****************************************

reg  [`OP_W-1:0]    s2_op_ff;
reg  [ADDR_W-1:0]   s2_addr_ff;
reg  [LANES-1:0]    s2_bw_n_ff;
reg  [DATA_W-1:0]   dq_out_ff;
reg  [LANES-1:0]    par_out_ff;

always @(posedge clk_i or negedge rst_n)
begin
    if (!rst_n)
    begin
        s2_op_ff   <= `OP_IDLE;
        s2_addr_ff <= {ADDR_W{`BIT_LOW}};
        s2_bw_n_ff <= {LANES{`BIT_HIGH}};
        dq_out_ff  <= {DATA_W{`BIT_LOW}};
        par_out_ff <= {LANES{`BIT_LOW}};
    end
    else if (step)
    begin
        s2_op_ff   <= s1_op_ff;
        s2_addr_ff <= beat_addr;
        s2_bw_n_ff <= s1_bw_n_ff;
        if (s1_op_ff == `OP_READ)
        begin
            dq_out_ff  <= rd_data_i;
            par_out_ff <= rd_parity_i;
        end
    end
end

// ****************************************
// pin direction
// ****************************************

wire                auto_float;
wire                drive;

// deselected, leaving deselect, or write data phase
assign auto_float = (s2_op_ff == `OP_IDLE) | (s2_op_ff == `OP_WRITE)
                  | ((s2_op_ff == `OP_IDLE) & (s1_op_ff != `OP_IDLE));
// output enable acts without the clock
assign drive = (s2_op_ff == `OP_READ) & ~auto_float & ~out_en_n_i;

assign dq_oe_o           = drive;
assign parity_lines_oe_o = drive;
assign dq_o              = dq_out_ff;
assign parity_lines_o    = par_out_ff;

// ****************************************
// write capture and buffer
// ****************************************

wire                push;
wire [WORD_W-1:0]   in_word;
wire [WORD_W-1:0]   out_word;

assign push    = step & (s2_op_ff == `OP_WRITE);
// parity bit enabled by its own lane select
assign in_word = {s2_addr_ff, ~s2_bw_n_ff, parity_lines_i, dq_i};

two_entry_buf
#(
    .W           (WORD_W)
)
u_wr_buf
(
    .clk_i       (clk_i),
    .rst_n_i     (rst_n),
    .ce_i        (clk_en_i),
    .in_valid_i  (push),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (in_word),
    .out_valid_o (wr_valid_o),
    .out_ready_i (wr_ready_i),
    .out_data_o  (out_word)
);

assign wr_data_o    = out_word[DATA_W-1:0];
assign wr_parity_o  = out_word[DATA_W+LANES-1:DATA_W];
assign wr_byte_en_o = out_word[DATA_W+2*LANES-1:DATA_W+LANES];
assign wr_addr_o    = out_word[WORD_W-1:DATA_W+2*LANES];

// ****************************************
// test port serial pins
// ****************************************

test_serial_io u_test
(
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .ce_i    (clk_en_i),
    .tck_i   (tck_i),
    .tdi_i   (tdi_i),
    .tdo_o   (tdo_o)
);

endmodule // sram_data_io

// >>> verif/sram_data_io_asserts.sv
`timescale 1ns/1ps
module sram_data_io_asserts
#(
    parameter ADDR_W = 21,
    parameter LANES  = 4,
    parameter LANE_W = 8
)
(
    // clock and reset
    input wire                    clk_i,
    input wire                    arst_n_i,
    input wire                    clk_en_i,
    // synchronous controls and asynchronous output enable
    input wire                    clock_gate_n_i,
    input wire                    chip_sel_one_n_i,
    input wire                    chip_sel_two_i,
    input wire                    chip_sel_three_n_i,
    input wire                    write_en_n_i,
    input wire                    advance_or_load_i,
    input wire [ADDR_W-1:0]       addr_i,
    input wire                    out_en_n_i,
    // pins
    input wire [LANES*LANE_W-1:0] dq_i,
    input wire [LANES*LANE_W-1:0] dq_o,
    input wire                    dq_oe_o,
    input wire [LANES-1:0]        parity_lines_i,
    input wire [LANES-1:0]        parity_lines_o,
    input wire                    parity_lines_oe_o,
    input wire                    tck_i,
    input wire                    tdo_o,
    // core side
    input wire [ADDR_W-1:0]       rd_addr_o,
    input wire                    rd_en_o,
    input wire [LANES*LANE_W-1:0] rd_data_i,
    input wire [LANES-1:0]        rd_parity_i,
    input wire                    wr_valid_o,
    input wire                    wr_ready_i,
    input wire [LANES*LANE_W-1:0] wr_data_o,
    input wire [LANES-1:0]        wr_parity_o
);
    // ******
    // helper terms
    // ******
    wire stp = clk_en_i && !clock_gate_n_i && !wr_valid_o;
    wire sel = !chip_sel_one_n_i && chip_sel_two_i && !chip_sel_three_n_i;
    wire ld  = stp && !advance_or_load_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    a_oe_high_float: assert property (out_en_n_i |-> !dq_oe_o)
        else $error("pins driven with output enable high");
    a_parity_oe_same: assert property (parity_lines_oe_o == dq_oe_o)
        else $error("parity enable differs from data enable");
    a_gate_hold_out: assert property (clock_gate_n_i |=> $stable(dq_o) && $stable(parity_lines_o))
        else $error("outputs moved while clock gated");
    a_read_load_addr: assert property (ld && sel && write_en_n_i |=> rd_addr_o == $past(addr_i)
        && (rd_en_o || clock_gate_n_i || !clk_en_i))
        else $error("selected read not launched");
    a_desel_no_read: assert property (ld && !sel |=> !rd_en_o)
        else $error("read launched while deselected");
    a_read_data_next: assert property (rd_en_o && stp |=> dq_o == $past(rd_data_i)
        && parity_lines_o == $past(rd_parity_i))
        else $error("read data not on next edge");
    a_read_drive_on: assert property ((rd_en_o && stp ##1 !out_en_n_i) |-> dq_oe_o)
        else $error("read data not driven");
    a_write_float_pins: assert property ((ld && sel && !write_en_n_i ##1 stp) |=> !dq_oe_o)
        else $error("pins driven in write data phase");
    a_write_capture: assert property ((ld && sel && !write_en_n_i ##1 stp ##1 stp) |=> wr_valid_o
        && wr_data_o == $past(dq_i) && wr_parity_o == $past(parity_lines_i))
        else $error("write data not captured");
    a_tdo_fall_only: assert property ($changed(tdo_o) |-> !$past(tck_i) && !$past(tck_i, 2))
        else $error("test output moved outside low test clock");

    c_read: cover property (rd_en_o && stp);
    c_stall: cover property (wr_valid_o && !wr_ready_i ##1 wr_valid_o);
    c_gate: cover property (clock_gate_n_i && rd_en_o);
endmodule // sram_data_io_asserts

bind sram_data_io sram_data_io_asserts #(.ADDR_W(ADDR_W), .LANES(LANES), .LANE_W(LANE_W)) u_chk (.*);

// >>> verif/ctrl_model.sv
`timescale 1ns/1ps
module ctrl_model
(
    // clock
    input  wire         clk_i,
    // synchronous controls
    output logic        gate_n_o,
    output logic [2:0]  sel_o,
    output logic        we_n_o,
    output logic        adv_o,
    output logic [20:0] addr_o,
    output logic [3:0]  bw_n_o,
    // enable, strap, data
    output logic        oe_n_o,
    output logic        mode_o,
    output logic [31:0] dq_o,
    output logic [3:0]  par_o
);
    logic drv_ff;
    initial
    begin
        gate_n_o = 1'h0;
        sel_o    = 3'h6;
        we_n_o   = 1'h1;
        adv_o    = 1'h0;
        addr_o   = 21'h0;
        bw_n_o   = 4'hf;
        oe_n_o   = 1'h0;
        mode_o   = 1'h1;
        dq_o     = 32'h0;
        par_o    = 4'h0;
        drv_ff   = 1'h0;
    end
    // released lines toggle every cycle
    always @(posedge clk_i)
    begin
        if (!drv_ff)
        begin
            dq_o  <= ~dq_o;
            par_o <= ~par_o;
        end
    end
    task automatic cyc(input logic [2:0] s, input logic w, input logic a, input logic [20:0] ad);
        @(posedge clk_i);
        #1;
        drv_ff = 1'h0;
        sel_o  = s;
        we_n_o = w;
        adv_o  = a;
        addr_o = ad;
    endtask
    task automatic put(input logic [31:0] d, input logic [3:0] p);
        drv_ff = 1'h1;
        dq_o   = d;
        par_o  = p;
    endtask
endmodule // ctrl_model

// >>> verif/sram_data_io_bench.sv
`timescale 1ns/1ps
module sram_data_io_bench;
    localparam logic [2:0] SEL = 3'h2;
    localparam logic [2:0] DS  = 3'h6;
    logic clk_i, arst_n_i, clk_en_i, wr_ready_i, tck_i, tdi_i;
    wire  clock_gate_n_i, chip_sel_one_n_i, chip_sel_two_i, chip_sel_three_n_i;
    wire  write_en_n_i, advance_or_load_i, out_en_n_i, burst_order_i;
    wire  dq_oe_o, parity_lines_oe_o, tdo_o, rd_en_o, wr_valid_o;
    wire [20:0] addr_i, rd_addr_o, wr_addr_o;
    wire [3:0]  byte_write_sel_n_i, parity_lines_i, parity_lines_o, rd_parity_i, wr_byte_en_o, wr_parity_o;
    wire [31:0] dq_i, dq_o, rd_data_i, wr_data_o;
    int failures;
    int num_checks;

    sram_data_io dut (.*);
    ctrl_model ctl (.clk_i(clk_i), .gate_n_o(clock_gate_n_i),
        .sel_o({chip_sel_one_n_i, chip_sel_two_i, chip_sel_three_n_i}), .we_n_o(write_en_n_i),
        .adv_o(advance_or_load_i), .addr_o(addr_i), .bw_n_o(byte_write_sel_n_i), .oe_n_o(out_en_n_i),
        .mode_o(burst_order_i), .dq_o(dq_i), .par_o(parity_lines_i));
    assign rd_data_i   = {rd_addr_o[15:0], ~rd_addr_o[15:0]};
    assign rd_parity_i = rd_addr_o[3:0];

    initial
    begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic chk(input logic ok, input string m);
        num_checks++;
        if (ok !== 1'h1)
        begin
            failures++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic close_out;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ******
    // scenarios
    // ******
    task automatic t_read;
        ctl.cyc(SEL, 1'h1, 1'h0, 21'h1_2344);
        ctl.cyc(DS, 1'h1, 1'h0, 21'h0);
        chk(rd_en_o === 1'h1 && rd_addr_o === 21'h1_2344, "read launch");
        ctl.cyc(DS, 1'h1, 1'h0, 21'h0);
        chk(dq_o === 32'h2344_dcbb && parity_lines_o === 4'h4 && dq_oe_o === 1'h1, "read data");
        ctl.oe_n_o = 1'h1;
        #1;
        chk(dq_oe_o === 1'h0 && parity_lines_oe_o === 1'h0, "enable high");
        ctl.oe_n_o = 1'h0;
        ctl.cyc(DS, 1'h1, 1'h0, 21'h0);
        chk(dq_oe_o === 1'h0, "deselect float");
    endtask
    task automatic t_gate;
        ctl.cyc(SEL, 1'h1, 1'h0, 21'h55);
        ctl.cyc(DS, 1'h1, 1'h0, 21'h0);
        ctl.gate_n_o = 1'h1;
        wt(4);
        chk(rd_en_o === 1'h0 && dq_o === 32'h2344_dcbb && dq_oe_o === 1'h0, "gate hold");
        ctl.gate_n_o = 1'h0;
        wt(1);
        chk(dq_o === 32'h0055_ffaa && dq_oe_o === 1'h1, "gate resume");
        clk_en_i = 1'h0;
        wt(3);
        chk(dq_o === 32'h0055_ffaa && dq_oe_o === 1'h1, "enable hold");
        clk_en_i = 1'h1;
        ctl.cyc(DS, 1'h1, 1'h0, 21'h0);
        chk(dq_oe_o === 1'h0, "float after");
    endtask
    task automatic t_sel;
        for (int s = 0; s < 8; s++)
        begin
            ctl.cyc(s[2:0], 1'h1, 1'h0, 21'h100);
            ctl.cyc(DS, 1'h1, 1'h0, 21'h0);
            chk(rd_en_o === (s == 2), "select decode");
        end
    endtask
    task automatic t_burst;
        ctl.cyc(SEL, 1'h1, 1'h0, 21'h201);
        for (int i = 0; i < 4; i++)
        begin
            ctl.cyc(SEL, 1'h1, i < 3, 21'h201);
            chk(rd_en_o === 1'h1 && rd_addr_o === (21'h201 ^ i[20:0]), "burst order");
        end
        ctl.cyc(DS, 1'h1, 1'h0, 21'h0);
    endtask
    task automatic t_write;
        wr_ready_i = 1'h0;
        ctl.bw_n_o = 4'ha;
        ctl.cyc(SEL, 1'h0, 1'h0, 21'h300);
        ctl.cyc(SEL, 1'h0, 1'h0, 21'h301);
        ctl.cyc(DS, 1'h1, 1'h0, 21'h0);
        chk(dq_oe_o === 1'h0, "write float");
        ctl.put(32'h1234_5678, 4'h9);
        ctl.cyc(DS, 1'h1, 1'h0, 21'h0);
        ctl.put(32'h9abc_def0, 4'h6);
        ctl.cyc(SEL, 1'h1, 1'h0, 21'h400);
        ctl.cyc(DS, 1'h1, 1'h0, 21'h0);
        chk(rd_en_o === 1'h0 && wr_valid_o === 1'h1, "full refuses");
        wt(3);
        chk(wr_addr_o === 21'h300 && wr_data_o === 32'h1234_5678, "head kept");
        chk(wr_byte_en_o === 4'h5 && wr_parity_o === 4'h9, "lanes");
        wr_ready_i = 1'h1;
        wt(1);
        chk(wr_addr_o === 21'h301 && wr_data_o === 32'h9abc_def0 && wr_parity_o === 4'h6, "second");
        wt(1);
        chk(wr_valid_o === 1'h0, "drained");
    endtask
    task automatic t_test;
        tdi_i = 1'h1;
        tck_i = 1'h1;
        wt(8);
        tdi_i = 1'h0;
        tck_i = 1'h0;
        wt(8);
        chk(tdo_o === 1'h1, "shift one");
        tck_i = 1'h1;
        wt(8);
        chk(tdo_o === 1'h1, "rise keeps");
        tck_i = 1'h0;
        wt(8);
        chk(tdo_o === 1'h0, "shift zero");
    endtask
    task automatic t_linear;
        ctl.mode_o = 1'h0;
        arst_n_i   = 1'h0;
        wt(2);
        arst_n_i   = 1'h1;
        wt(8);
        chk(dq_oe_o === 1'h0 && wr_valid_o === 1'h0 && dq_o === 32'h0, "reset values");
        ctl.cyc(SEL, 1'h1, 1'h0, 21'h201);
        for (int i = 0; i < 4; i++)
        begin
            ctl.cyc(SEL, 1'h1, i < 3, 21'h201);
            chk(rd_en_o === 1'h1 && rd_addr_o === 21'h200 + ((i + 1) % 4), "linear order");
        end
        ctl.cyc(DS, 1'h1, 1'h0, 21'h0);
    endtask

    initial
    begin
        #20000;
        failures++;
        close_out;
    end
    initial
    begin
        arst_n_i   = 1'h0;
        clk_en_i   = 1'h1;
        wr_ready_i = 1'h1;
        tck_i      = 1'h0;
        tdi_i      = 1'h0;
        failures   = 0;
        num_checks = 0;
        repeat (6) @(posedge clk_i);
        #1;
        arst_n_i = 1'h1;
        wt(4);
        t_read;
        t_gate;
        t_sel;
        t_burst;
        t_write;
        t_test;
        t_linear;
        close_out;
    end
endmodule // sram_data_io_bench
